// >>> include/lcd_defs.svh
// Constants for the LED capacity gauge and initialization block.
`ifndef LCD_DEFS_SVH
`define LCD_DEFS_SVH
`define LCD_CLK_HZ 125000000
`define LCD_MOD_HZ 100
`define LCD_BLINK_HZ 4
`define LCD_BANK_PCT 30
`define LCD_WIN_SINGLE_S 10
`define LCD_WIN_SHORT_S 4
`define LCD_CMD_WORD_ADDR 7'h00
`define LCD_CMD_REINIT 8'h78
`define LCD_RCHG_FULL 8'h64
`define LCD_FLAGS_FULL 8'h90
`define LCD_FLAGS_EMPTY 8'h10
`define LCD_FINAL_EMPTY_WARNING_OFFSET_MV 100
`define LCD_PCT_90 8'h5A
`define LCD_PCT_80 8'h50
`define LCD_PCT_70 8'h46
`define LCD_PCT_60 8'h3C
`define LCD_PCT_50 8'h32
`define LCD_PCT_40 8'h28
`define LCD_PCT_20 8'h14
`define LCD_PCT_10 8'h0A
`define LCD_PCT_SCALE 100
`endif

// >>> include/lcd_pkg.sv
// Types shared by the LED capacity gauge files.
package lcd_pkg;
    typedef enum logic [1:0] {LCD_MODE_SINGLE, LCD_MODE_BINARY, LCD_MODE_BAR} lcd_mode_t;
    typedef enum logic [1:0] {LCD_STRAP_LOW, LCD_STRAP_HIGH, LCD_STRAP_FLOAT} lcd_strap_t;
    typedef enum logic {LCD_IDLE, LCD_SHOW} lcd_state_t;
endpackage

// >>> core/lcd_percent.sv
// Relative capacity in whole percent, registered.
`timescale 1ns/10ps
`include "lcd_defs.svh"
module lcd_percent #(
    parameter int W = 16
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Operands
    input wire logic [W-1:0] i_capacity,
    input wire logic [W-1:0] i_full,
    // Result
    output logic [7:0] o_percent
);
    logic [7:0] next_percent;
    logic [W+7:0] scaled;
    logic [W+7:0] quotient;

    always_comb
    begin
        scaled = (W+8)'(i_capacity) * (W+8)'(`LCD_PCT_SCALE);
        quotient = (i_full == '0) ? '0 : scaled / (W+8)'(i_full);
        // Quotients above 8'hFF saturate rather than wrap.
        next_percent = (quotient > (W+8)'(8'hFF)) ? 8'hFF : quotient[7:0];
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_percent <= 8'h00;
        else if (i_ce)
            o_percent <= next_percent;
    end
endmodule // lcd_percent

// >>> core/lcd_gauge.sv
// LED capacity gauge with timed display and initialization values.
`timescale 1ns/10ps
`include "lcd_defs.svh"
module lcd_gauge #(
    parameter int W = 16,
    parameter int VW = 8,
    parameter int WIN_SINGLE_CYC = `LCD_CLK_HZ * `LCD_WIN_SINGLE_S,
    parameter int WIN_SHORT_CYC = `LCD_CLK_HZ * `LCD_WIN_SHORT_S,
    parameter int MOD_PERIOD_CYC = `LCD_CLK_HZ / `LCD_MOD_HZ,
    parameter int BLINK_HALF_CYC = `LCD_CLK_HZ / (2 * `LCD_BLINK_HZ),
    parameter logic [VW-1:0] FINAL_EMPTY_WARNING_OFFSET_CODE = VW'(8'h15)
) (
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Display request and straps
    input wire logic i_display_request_n,
    input wire logic [1:0] i_display_mode_strap,
    input wire logic i_initial_capacity_strap,
    // Capacity and voltage inputs
    input wire logic [W-1:0] i_compensated_capacity,
    input wire logic [W-1:0] i_full_capacity_reference,
    input wire logic [7:0] i_programmed_full_count,
    input wire logic [VW-1:0] i_battery_sense_voltage,
    input wire logic [VW-1:0] i_first_threshold,
    // Register writes from the serial link
    input wire logic i_reg_wr,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    // Segment pins
    output logic [4:0] o_led_out,
    output logic [4:0] o_led_oe,
    // Initialization results
    output logic o_init_load,
    output logic [7:0] o_full_capacity_reference,
    output logic [7:0] o_compensated_capacity_high,
    output logic [7:0] o_compensated_capacity_low,
    output logic [7:0] o_relative_charge,
    output logic [7:0] o_primary_flags,
    // Warning flags
    output logic o_first_empty_warning,
    output logic o_final_empty_warning
);
    lcd_pkg::lcd_state_t state, next_state;
    lcd_pkg::lcd_mode_t mode;
    logic [31:0] win_cnt, next_win_cnt;
    logic [31:0] mod_cnt, next_mod_cnt;
    logic [31:0] blink_cnt, next_blink_cnt;
    logic blink, next_blink;
    logic req_d, next_req_d;
    logic [4:0] led_on, next_led_on;
    logic first_warn, next_first_warn;
    logic final_warn, next_final_warn;
    logic init_load, next_init_load;
    logic [7:0] r_full_capacity_reference, r_compensated_capacity_high, r_compensated_capacity_low, r_rchg, r_flags;
    logic [7:0] next_full_capacity_reference, next_compensated_capacity_high, next_compensated_capacity_low, next_rchg, next_flags;
    logic [7:0] pct;
    logic [4:0] pattern;
    logic [4:0] bank_mask;
    logic req_fall;
    logic reinit;
    logic [VW-1:0] final_threshold;
    localparam logic [31:0] BANK_CYC = 32'(MOD_PERIOD_CYC * `LCD_BANK_PCT / 100);
    localparam logic [31:0] HALF_CYC = 32'(MOD_PERIOD_CYC / 2);

    lcd_percent #(
        .W(W)
    ) u_percent (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_capacity(i_compensated_capacity),
        .i_full(i_full_capacity_reference),
        .o_percent(pct)
    );

    // Strap decode: the floating state is reported as code 2 by the pad logic.
    always_comb
    begin
        unique case (i_display_mode_strap)
            2'h0: mode = lcd_pkg::LCD_MODE_SINGLE;
            2'h1: mode = lcd_pkg::LCD_MODE_BINARY;
            default: mode = lcd_pkg::LCD_MODE_BAR;
        endcase
    end

    // Pattern per mode from the relative capacity.
    always_comb
    begin
        pattern = 5'h00;
        unique case (mode)
            lcd_pkg::LCD_MODE_SINGLE:
            begin
                if (pct >= `LCD_PCT_90)
                    pattern = 5'h08;
                else if (pct >= `LCD_PCT_50)
                    pattern = 5'h04;
                else if (pct >= `LCD_PCT_20)
                    pattern = 5'h02;
                else
                    pattern = 5'h01;
                if (first_warn && pattern[0])
                    pattern[0] = blink;
            end
            lcd_pkg::LCD_MODE_BINARY:
            begin
                if (pct >= `LCD_PCT_70)
                    pattern = 5'h03;
                else if (pct >= `LCD_PCT_40)
                    pattern = 5'h01;
                else if (pct >= `LCD_PCT_10)
                    pattern = 5'h02;
                else
                    pattern = 5'h00;
            end
            lcd_pkg::LCD_MODE_BAR:
            begin
                if (pct >= `LCD_PCT_80)
                    pattern = 5'h1F;
                else if (pct >= `LCD_PCT_60)
                    pattern = 5'h0F;
                else if (pct >= `LCD_PCT_40)
                    pattern = 5'h07;
                else if (pct >= `LCD_PCT_20)
                    pattern = 5'h03;
                else
                    pattern = 5'h01;
                // The bar blinks only the first segment and drops the rest.
                if (first_warn)
                    pattern = {4'h0, blink};
            end
        endcase
        if (final_warn)
            pattern = 5'h00;
    end

    // Bank one (segments 1,3,5) leads each period, bank two starts at half period.
    always_comb
    begin
        bank_mask = 5'h00;
        if (mod_cnt < BANK_CYC)
            bank_mask = 5'h15;
        else if (mod_cnt >= HALF_CYC && mod_cnt < HALF_CYC + BANK_CYC)
            bank_mask = 5'h0A;
    end

    assign req_fall = req_d && !i_display_request_n;
    assign reinit = i_reg_wr && i_reg_addr == `LCD_CMD_WORD_ADDR && i_reg_wdata == `LCD_CMD_REINIT;
    // Saturate so a very low first threshold never wraps the final one.
    assign final_threshold = (i_first_threshold > FINAL_EMPTY_WARNING_OFFSET_CODE) ?
        i_first_threshold - FINAL_EMPTY_WARNING_OFFSET_CODE : '0;

    always_comb
    begin
        next_state = state;
        next_win_cnt = win_cnt;
        next_req_d = i_display_request_n;
        next_mod_cnt = (mod_cnt >= 32'(MOD_PERIOD_CYC - 1)) ? 32'h0 : mod_cnt + 32'h1;
        next_blink_cnt = blink_cnt + 32'h1;
        next_blink = blink;
        if (blink_cnt >= 32'(BLINK_HALF_CYC - 1))
        begin
            next_blink_cnt = 32'h0;
            next_blink = !blink;
        end
        next_first_warn = i_battery_sense_voltage < i_first_threshold;
        next_final_warn = i_battery_sense_voltage < final_threshold;
        unique case (state)
            lcd_pkg::LCD_IDLE:
            begin
                if (req_fall)
                begin
                    next_state = lcd_pkg::LCD_SHOW;
                    next_win_cnt = (mode == lcd_pkg::LCD_MODE_SINGLE) ?
                        32'(WIN_SINGLE_CYC - 1) : 32'(WIN_SHORT_CYC - 1);
                end
            end
            lcd_pkg::LCD_SHOW:
            begin
                // A fresh request here is ignored until the window ends.
                if (win_cnt == 32'h0)
                    next_state = lcd_pkg::LCD_IDLE;
                else
                    next_win_cnt = win_cnt - 32'h1;
            end
        endcase
        next_led_on = (next_state == lcd_pkg::LCD_SHOW) ? pattern & bank_mask : 5'h00;
    end

    always_comb
    begin
        next_init_load = reinit;
        next_full_capacity_reference = r_full_capacity_reference;
        next_compensated_capacity_high = r_compensated_capacity_high;
        next_compensated_capacity_low = r_compensated_capacity_low;
        next_rchg = r_rchg;
        next_flags = r_flags;
        if (reinit)
        begin
            if (i_initial_capacity_strap)
            begin
                next_full_capacity_reference = i_programmed_full_count;
                next_compensated_capacity_high = i_programmed_full_count;
                next_compensated_capacity_low = 8'h00;
                next_rchg = `LCD_RCHG_FULL;
                next_flags = `LCD_FLAGS_FULL;
            end
            else
            begin
                next_full_capacity_reference = 8'h00;
                next_compensated_capacity_high = 8'h00;
                next_compensated_capacity_low = 8'h00;
                next_rchg = 8'h00;
                next_flags = `LCD_FLAGS_EMPTY;
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= lcd_pkg::LCD_IDLE;
            win_cnt <= 32'h0;
            mod_cnt <= 32'h0;
            blink_cnt <= 32'h0;
            blink <= 1'b0;
            req_d <= 1'b1;
            led_on <= 5'h00;
            first_warn <= 1'b0;
            final_warn <= 1'b0;
            init_load <= 1'b0;
            r_full_capacity_reference <= 8'h00;
            r_compensated_capacity_high <= 8'h00;
            r_compensated_capacity_low <= 8'h00;
            r_rchg <= 8'h00;
            r_flags <= 8'h00;
        end
        else if (i_ce)
        begin
            state <= next_state;
            win_cnt <= next_win_cnt;
            mod_cnt <= next_mod_cnt;
            blink_cnt <= next_blink_cnt;
            blink <= next_blink;
            req_d <= next_req_d;
            led_on <= next_led_on;
            first_warn <= next_first_warn;
            final_warn <= next_final_warn;
            init_load <= next_init_load;
            r_full_capacity_reference <= next_full_capacity_reference;
            r_compensated_capacity_high <= next_compensated_capacity_high;
            r_compensated_capacity_low <= next_compensated_capacity_low;
            r_rchg <= next_rchg;
            r_flags <= next_flags;
        end
    end

    // Segments are open drain: ON pulls low, OFF releases.
    assign o_led_out = 5'h00;
    assign o_led_oe = led_on;
    assign o_init_load = init_load;
    assign o_full_capacity_reference = r_full_capacity_reference;
    assign o_compensated_capacity_high = r_compensated_capacity_high;
    assign o_compensated_capacity_low = r_compensated_capacity_low;
    assign o_relative_charge = r_rchg;
    assign o_primary_flags = r_flags;
    assign o_first_empty_warning = first_warn;
    assign o_final_empty_warning = final_warn;
endmodule // lcd_gauge

// >>> sim/lcd_gauge_asserts.sv
// Checker for the LED capacity gauge, bound to its top module.
`timescale 1ns/10ps
`include "lcd_defs.svh"
module lcd_gauge_check #(
    parameter int VW = 8
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Inputs watched
    input wire logic i_reg_wr,
    input wire logic [6:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_initial_capacity_strap,
    input wire logic [7:0] i_programmed_full_count,
    input wire logic [VW-1:0] i_battery_sense_voltage,
    input wire logic [VW-1:0] i_first_threshold,
    // Outputs watched
    input wire logic [4:0] o_led_out,
    input wire logic [4:0] o_led_oe,
    input wire logic o_init_load,
    input wire logic [7:0] o_full_capacity_reference,
    input wire logic [7:0] o_compensated_capacity_high,
    input wire logic [7:0] o_compensated_capacity_low,
    input wire logic [7:0] o_relative_charge,
    input wire logic [7:0] o_primary_flags,
    input wire logic o_first_empty_warning,
    input wire logic o_final_empty_warning
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_reinit;
        i_ce && i_reg_wr && i_reg_addr == 7'h00 && i_reg_wdata == 8'h78;
    endsequence
    sequence s_load_high;
        o_init_load && $past(i_ce) && $past(i_initial_capacity_strap);
    endsequence
    chk_data_low: assert property (o_led_out == 5'h00) else $error("segment data not low");
    chk_banks_apart: assert property (!((o_led_oe[0] | o_led_oe[2] | o_led_oe[4]) && (o_led_oe[1] | o_led_oe[3])))
        else $error("both banks on");
    // A low enable freezes the banks, so the width is only judged across enabled cycles.
    chk_bank_one_width: assert property (($rose(o_led_oe[0]) && i_ce) ##1 i_ce [*5] |=> !o_led_oe[0])
        else $error("bank too long");
    chk_bank_two_width: assert property (($rose(o_led_oe[1]) && i_ce) ##1 i_ce [*5] |=> !o_led_oe[1])
        else $error("bank too long");
    chk_final_blank: assert property (o_final_empty_warning ##1 (o_final_empty_warning && $past(i_ce)) |->
        o_led_oe == 5'h00) else $error("lit at final warning");
    chk_reinit_load: assert property (s_reinit |=> o_init_load) else $error("no init load");
    chk_load_cause: assert property (o_init_load && $past(i_ce) |-> $past(i_ce && i_reg_wr && i_reg_addr == 7'h00 &&
        i_reg_wdata == 8'h78)) else $error("init load uncaused");
    chk_init_high: assert property (s_load_high |-> o_primary_flags == 8'h90 && o_relative_charge == 8'h64 &&
        o_compensated_capacity_low == 8'h00 && o_full_capacity_reference == $past(i_programmed_full_count) &&
        o_compensated_capacity_high == $past(i_programmed_full_count)) else $error("bad high init");
    chk_init_low: assert property (o_init_load && $past(i_ce) && !$past(i_initial_capacity_strap) |->
        o_primary_flags == 8'h10 &&
        {o_full_capacity_reference, o_compensated_capacity_high, o_compensated_capacity_low, o_relative_charge}
        == 32'h00000000) else $error("bad low init");
    chk_first_warn: assert property (!$past(i_rst) && $past(i_ce) |-> o_first_empty_warning ==
        $past(i_battery_sense_voltage < i_first_threshold)) else $error("first warning wrong");
    chk_final_below: assert property (o_final_empty_warning |-> o_first_empty_warning)
        else $error("final without first");
endmodule // lcd_gauge_check
bind lcd_gauge lcd_gauge_check #(.VW(VW)) i_lcd_gauge_check (.i_clk, .i_rst, .i_ce, .i_reg_wr, .i_reg_addr,
    .i_reg_wdata, .i_initial_capacity_strap, .i_programmed_full_count, .i_battery_sense_voltage,
    .i_first_threshold, .o_led_out, .o_led_oe, .o_init_load, .o_full_capacity_reference,
    .o_compensated_capacity_high, .o_compensated_capacity_low, .o_relative_charge, .o_primary_flags,
    .o_first_empty_warning, .o_final_empty_warning);

// >>> sim/lcd_led_model.sv
// Behavioural LED segments and strap resistor at the gauge pins.
`timescale 1ns/10ps
module lcd_led_model (
    // Segment pins from the gauge
    input wire logic [4:0] i_led_out,
    input wire logic [4:0] i_led_oe,
    // Strap setting wanted by the bench
    input wire logic [1:0] i_mode,
    // Light seen and strap code
    output logic [4:0] o_lit,
    output logic [1:0] o_mode_strap
);
    // A released pin is pulled to the supply through its LED, so only a driven low pin lights.
    assign o_lit = ~((i_led_oe & i_led_out) | ~i_led_oe);
    assign o_mode_strap = i_mode;
endmodule // lcd_led_model

// >>> sim/lcd_gauge_tb.sv
// Self-checking testbench for the LED capacity gauge.
`timescale 1ns/10ps
module lcd_gauge_tb;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic dreq_n = 1'b1;
    logic [1:0] mode = 2'h2;
    logic [1:0] strap;
    logic ics = 1'b1;
    logic ce = 1'b1;
    logic [15:0] full = 16'h0064;
    logic [15:0] cap = 16'h0000;
    logic [7:0] programmed_full_count = 8'hA5;
    logic [7:0] v = 8'hFF;
    logic [7:0] th = 8'h50;
    logic wr = 1'b0;
    logic [6:0] addr = 7'h00;
    logic [7:0] wd = 8'h00;
    logic [4:0] out;
    logic [4:0] oe;
    logic [4:0] lit;
    logic ld;
    logic [7:0] fn, ch, cl, rc, fl;
    logic w1, wf;
    int bad_count = 0;
    int tests_run = 0;
    lcd_gauge #(.WIN_SINGLE_CYC(100), .WIN_SHORT_CYC(40), .MOD_PERIOD_CYC(20), .BLINK_HALF_CYC(8)) i_lcd_gauge (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_display_request_n(dreq_n), .i_display_mode_strap(strap),
        .i_initial_capacity_strap(ics), .i_compensated_capacity(cap), .i_full_capacity_reference(full),
        .i_programmed_full_count(programmed_full_count), .i_battery_sense_voltage(v), .i_first_threshold(th), .i_reg_wr(wr),
        .i_reg_addr(addr), .i_reg_wdata(wd), .o_led_out(out), .o_led_oe(oe), .o_init_load(ld),
        .o_full_capacity_reference(fn), .o_compensated_capacity_high(ch), .o_compensated_capacity_low(cl),
        .o_relative_charge(rc), .o_primary_flags(fl), .o_first_empty_warning(w1), .o_final_empty_warning(wf));
    lcd_led_model i_lcd_led_model (.i_led_out(out), .i_led_oe(oe), .i_mode(mode), .o_lit(lit),
        .o_mode_strap(strap));
    initial
    begin
        forever #4 i_clk = ~i_clk;
    end
    task step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task chk(input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e)
        begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wrt(input logic [6:0] a, input logic [7:0] d);
        // An idle edge first, so back-to-back writes never drop and raise the strobe in one step.
        step(1);
        wr = 1'b1;
        addr = a;
        wd = d;
        step(1);
        wr = 1'b0;
    endtask
    task req();
        dreq_n = 1'b0;
        step(1);
        dreq_n = 1'b1;
    endtask
    task acc(input int k, output logic [4:0] a, output int n);
        a = 5'h00;
        n = 0;
        repeat (k)
        begin
            step(1);
            a |= lit;
            n += int'(lit[0]);
        end
    endtask
    task t_one(input logic [1:0] m, input logic [7:0] p, input logic [4:0] e);
        logic [4:0] a;
        int n;
        mode = m;
        cap = {8'h00, p};
        step(3);
        req();
        acc(20, a, n);
        chk(8'(a), 8'(e));
        chk(8'(n), e[0] ? 8'h06 : 8'h00);
        step(40);
        acc(20, a, n);
        chk(8'(a), m == 2'h0 ? 8'(e) : 8'h00);
        step(40);
        acc(20, a, n);
        chk(8'(a), 8'h00);
    endtask
    task t_init();
        ics = 1'b1;
        wrt(7'h00, 8'h78);
        chk(8'(ld), 8'h01);
        chk(fn, 8'hA5);
        chk(ch, 8'hA5);
        chk(cl | {7'h00, ld ^ 1'b1}, 8'h00);
        chk(rc, 8'h64);
        chk(fl, 8'h90);
        ics = 1'b0;
        wrt(7'h00, 8'h78);
        chk(fn | ch | cl | rc, 8'h00);
        chk(fl, 8'h10);
        wrt(7'h01, 8'h78);
        chk(8'(ld), 8'h00);
        wrt(7'h00, 8'h55);
        chk(8'(ld), 8'h00);
        $display("t_init done");
    endtask
    task t_modes();
        t_one(2'h0, 8'h5A, 5'h08);
        t_one(2'h0, 8'h32, 5'h04);
        t_one(2'h0, 8'h14, 5'h02);
        t_one(2'h0, 8'h13, 5'h01);
        t_one(2'h1, 8'h46, 5'h03);
        t_one(2'h1, 8'h28, 5'h01);
        t_one(2'h1, 8'h27, 5'h02);
        t_one(2'h1, 8'h09, 5'h00);
        t_one(2'h2, 8'h50, 5'h1F);
        t_one(2'h2, 8'h3C, 5'h0F);
        t_one(2'h3, 8'h28, 5'h07);
        t_one(2'h2, 8'h14, 5'h03);
        t_one(2'h2, 8'h13, 5'h01);
        $display("t_modes done");
    endtask
    task t_retrig();
        logic [4:0] a;
        int n;
        mode = 2'h0;
        cap = 16'h005F;
        req();
        step(50);
        req();
        step(50);
        acc(20, a, n);
        chk(8'(a), 8'h00);
        $display("t_retrig done");
    endtask
    task t_warn();
        logic [4:0] a, b;
        int n;
        mode = 2'h2;
        cap = 16'h0064;
        v = 8'h46;
        step(3);
        chk({6'h00, w1, wf}, 8'h02);
        // One short window can fall wholly between blink and bank overlaps, so two are watched.
        req();
        acc(40, a, n);
        req();
        acc(40, b, n);
        chk(8'(a | b), 8'h01);
        step(60);
        v = 8'h3A;
        step(3);
        chk(8'(wf), 8'h01);
        req();
        acc(20, a, n);
        chk(8'(a), 8'h00);
        v = 8'h3B;
        step(3);
        chk(8'(wf), 8'h00);
        v = 8'hFF;
        step(60);
        $display("t_warn done");
    endtask
    task t_hold();
        logic [4:0] a, s;
        int n;
        mode = 2'h0;
        full = 16'h00C8;
        cap = 16'h00B4;
        step(3);
        req();
        acc(20, a, n);
        chk(8'(a), 8'h08);
        ce = 1'b0;
        s = lit;
        wrt(7'h00, 8'h78);
        chk(8'(ld), 8'h00);
        acc(150, a, n);
        chk(8'(a), 8'(s));
        ce = 1'b1;
        acc(20, a, n);
        chk(8'(a), 8'h08);
        step(80);
        req();
        step(5);
        i_rst = 1'b1;
        step(1);
        chk(8'(oe), 8'h00);
        step(1);
        i_rst = 1'b0;
        step(2);
        acc(20, a, n);
        chk(8'(a), 8'h00);
        $display("t_hold done");
    endtask
    task end_of_test();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #(8 * 20000);
        bad_count++;
        end_of_test();
    end
    initial
    begin
        step(6);
        i_rst = 1'b0;
        step(2);
        t_init();
        t_modes();
        t_retrig();
        t_warn();
        t_hold();
        end_of_test();
    end
endmodule // lcd_gauge_tb
